// [config_startup_sequencer.sv]
// Configuration stream checker, security control and startup phase sequencer.
`timescale 1ns/1ps
`include "css_consts.svh"
// What this block does
// - Key comes from battery RAM by default or fuses, only when encrypted.
// - Authenticated streams need both AES and HMAC keys; HMAC checked in hardware.
// - With CRC on, compute stream CRC, compare embedded value, fail on mismatch.
// - With CRC off, skip calculation and ignore the constant in its place.
// - Debug mode zeroes legacy output, checks each frame, writes frame addresses.
// - Per-frame CRC failure flags init error and partial reconfig error first.
// - Test port lockout blocks scan access once configuration completes.
// - Active reconfig option suppresses global high hold and set/reset.
// - Route internal config access to top or bottom port; auto by default.
// - Level 1 blocks readback; level 2 blocks readback and reconfiguration.
// - Partial reconfig keeps converter running, or safe mode when enabled.
// - Done pipeline waits for external done high, then next startup edge.
// - Done output at selected phase, default 4, keep, delayed by pipeline.
// - I/O tristate released at selected phase, default 5, done-tied or keep.
// - Global write enable at selected phase, default 6, done-tied or keep.
// - Block RAM reads and writes stay disabled until write enable phase.
// - Stall at lock-wait phase until all clock generators lock, unless none.
// - Stall at match-wait phase until impedance match signals assert.
// - Startup steps on config clock, user clock, or test port clock.
// - With error signalling on, drive init error pin low on error.
module config_startup_sequencer (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     clkEn,
  input  wire css_pkg::options_type     options,
  input  wire css_pkg::stream_word_type streamWord,
  input  wire logic                     ramKeyValid,
  input  wire logic                     fuseKeyValid,
  input  wire logic                     hmacKeyValid,
  input  wire logic                     hmacMatch,
  input  wire logic                     configClkTick,
  input  wire logic                     userStartupClockTick,
  input  wire logic                     testPortClockTick,
  input  wire logic                     allClocksLocked,
  input  wire logic                     impedanceMatched,
  input  wire logic                     doneLineIn,
  input  wire logic                     partialReconfigActive,
  input  wire logic                     readbackReq,
  output logic                          doneOut_q,
  output logic                          initErrorN_q,
  output logic                          partialReconfigError_q,
  output logic                          configError_q,
  output logic [31:0]                   legacyOutputRegister_q,
  output logic                          frameCommit_q,
  output logic                          keyFromFuse_q,
  output logic                          hmacCheckEn_q,
  output logic                          scanAccessEn_q,
  output logic                          globalHighHold_q,
  output logic                          globalSetReset_q,
  output logic                          portTopEn_q,
  output logic                          portBottomEn_q,
  output logic                          readbackEn_q,
  output logic                          readbackGrant_q,
  output logic                          reconfigEn_q,
  output logic                          converterSafe_q,
  output logic                          ioRelease_q,
  output logic                          writeEnable_q,
  output logic                          bramEnable_q,
  output logic [2:0]                    startupPhase_q
);

  css_pkg::load_state_type state_q;
  logic [31:0]             streamCrc_q;
  logic [31:0]             frameCrc_q;
  logic [31:0]             frameAddr_q;
  logic                    configured_q;
  logic                    doneSeen_q;
  logic                    startupStep;
  logic                    stall;
  logic                    advance;
  logic                    keyOk;
  logic                    wordIn;
  logic                    frameChecked;
  logic                    crcFail;
  logic                    frameFail;
  logic                    syncAllowed;
  logic                    doneReached;

  // Bitwise CRC over one word; slow in gates but it keeps the polynomial in one place.
  function automatic logic [31:0] crcStep(input logic [31:0] crc, input logic [31:0] data);
    logic [31:0] c;
    c = crc;
    for (int i = 31; i >= 0; i--) begin
      c = (c[31] ^ data[i]) ? ((c << 1) ^ `CSS_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // A phase select is met once the sequencer has reached it; done-tied follows the done output; keep never is.
  function automatic logic phaseMet(input logic [2:0] sel, input logic [2:0] phase,
                                    input logic doneNow);
    if (sel == `CSS_PHASE_KEEP) begin
      return 1'b0;
    end
    if (sel == `CSS_PHASE_TIED_DONE) begin
      return doneNow;
    end
    return phase >= sel;
  endfunction

  assign wordIn = streamWord.valid;
  assign frameChecked = options.perFrameCheckOption | options.debugStreamOption;
  assign keyOk = !options.encryptEn ||
                 ((options.keySourceSelect ? fuseKeyValid : ramKeyValid) &&
                  (!options.authEn || hmacKeyValid));
  assign crcFail = wordIn && streamWord.kind == css_pkg::KIND_CRC && options.crcEn &&
                   streamWord.data != streamCrc_q;
  assign frameFail = wordIn && streamWord.kind == css_pkg::KIND_FRAME_CRC && frameChecked &&
                     streamWord.data != frameCrc_q;
  // A second configuration is refused at level 2 once the device is up.
  assign syncAllowed = !(configured_q && options.securityLevel == `CSS_SEC_LEVEL2);

  always_comb begin
    case (options.startupClockSelect)
      `CSS_CLK_CONFIG: startupStep = configClkTick;
      `CSS_CLK_USER:   startupStep = userStartupClockTick;
      `CSS_CLK_TEST:   startupStep = testPortClockTick;
      default:         startupStep = configClkTick;
    endcase
  end

  assign stall = (options.lockWaitPhaseSelect != `CSS_WAIT_NONE &&
                  startupPhase_q == options.lockWaitPhaseSelect && !allClocksLocked) ||
                 (options.matchWaitPhaseSelect != `CSS_WAIT_NONE &&
                  startupPhase_q == options.matchWaitPhaseSelect && !impedanceMatched);
  assign advance = state_q == css_pkg::ST_STARTUP && startupStep && !stall &&
                   (startupPhase_q != `CSS_PHASE_FINAL - 3'h1 ||
                    !options.donePipelineOption || doneSeen_q);
  assign doneReached = options.donePhaseSelect != `CSS_PHASE_KEEP &&
                       startupPhase_q >= options.donePhaseSelect;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= css_pkg::ST_IDLE;
      configured_q <= 1'b0;
    end else if (clkEn) begin
      case (state_q)
        css_pkg::ST_IDLE, css_pkg::ST_DONE: begin
          if (wordIn && streamWord.kind == css_pkg::KIND_SYNC && syncAllowed) begin
            state_q <= keyOk ? css_pkg::ST_LOAD : css_pkg::ST_ERROR;
          end
        end
        css_pkg::ST_LOAD: begin
          if (crcFail || frameFail) begin
            state_q <= css_pkg::ST_ERROR;
          end else if (wordIn && streamWord.kind == css_pkg::KIND_END) begin
            if (options.encryptEn && options.authEn && !hmacMatch) begin
              state_q <= css_pkg::ST_ERROR;
            end else if (configured_q) begin
              state_q <= css_pkg::ST_DONE;
            end else begin
              state_q <= css_pkg::ST_STARTUP;
            end
          end
        end
        css_pkg::ST_STARTUP: begin
          if (advance && startupPhase_q == `CSS_PHASE_FINAL - 3'h1) begin
            state_q <= css_pkg::ST_DONE;
            configured_q <= 1'b1;
          end
        end
        css_pkg::ST_ERROR: begin
          if (wordIn && streamWord.kind == css_pkg::KIND_SYNC && syncAllowed && keyOk) begin
            state_q <= css_pkg::ST_LOAD;
          end
        end
        default: state_q <= css_pkg::ST_IDLE;
      endcase
    end
  end

  // Running checks; the frame CRC restarts at each address word.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      streamCrc_q <= `CSS_CRC_SEED;
      frameCrc_q <= `CSS_CRC_SEED;
      frameAddr_q <= 32'h00000000;
    end else if (clkEn && wordIn) begin
      case (streamWord.kind)
        css_pkg::KIND_SYNC: begin
          streamCrc_q <= `CSS_CRC_SEED;
          frameCrc_q <= `CSS_CRC_SEED;
        end
        css_pkg::KIND_ADDR: begin
          frameAddr_q <= streamWord.data;
          frameCrc_q <= `CSS_CRC_SEED;
          if (options.crcEn) begin
            streamCrc_q <= crcStep(streamCrc_q, streamWord.data);
          end
        end
        css_pkg::KIND_DATA: begin
          if (options.crcEn) begin
            streamCrc_q <= crcStep(streamCrc_q, streamWord.data);
          end
          if (frameChecked) begin
            frameCrc_q <= crcStep(frameCrc_q, streamWord.data);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Frames commit at their frame check word; with frame checks on, a failing check blocks the commit.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frameCommit_q <= 1'b0;
      legacyOutputRegister_q <= 32'h00000000;
    end else if (clkEn) begin
      frameCommit_q <= state_q == css_pkg::ST_LOAD && wordIn && !frameFail &&
                       streamWord.kind == css_pkg::KIND_FRAME_CRC;
      if (options.debugStreamOption && wordIn) begin
        if (streamWord.kind == css_pkg::KIND_SYNC) begin
          legacyOutputRegister_q <= 32'h00000000;
        end else if (streamWord.kind == css_pkg::KIND_FRAME_CRC &&
                     state_q == css_pkg::ST_LOAD) begin
          legacyOutputRegister_q <= frameAddr_q;
        end
      end
    end
  end

  // Error flags are sticky: the frame flag until any sync word, the others until the load an accepted sync word starts.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      initErrorN_q <= 1'b1;
      partialReconfigError_q <= 1'b0;
      configError_q <= 1'b0;
    end else if (clkEn) begin
      if (state_q == css_pkg::ST_LOAD && frameFail) begin
        partialReconfigError_q <= 1'b1;
      end else if (wordIn && streamWord.kind == css_pkg::KIND_SYNC) begin
        partialReconfigError_q <= 1'b0;
      end
      if (state_q == css_pkg::ST_ERROR) begin
        configError_q <= 1'b1;
        initErrorN_q <= !options.errorSignalEn;
      end else if (state_q == css_pkg::ST_LOAD && (crcFail || frameFail)) begin
        configError_q <= 1'b1;
        initErrorN_q <= !options.errorSignalEn;
      end else if (state_q == css_pkg::ST_LOAD) begin
        configError_q <= 1'b0;
        initErrorN_q <= 1'b1;
      end
    end
  end

  // Startup phase counter and the done-line sample for the pipeline.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      startupPhase_q <= 3'h0;
      doneSeen_q <= 1'b0;
    end else if (clkEn) begin
      if (state_q != css_pkg::ST_STARTUP && state_q != css_pkg::ST_DONE) begin
        startupPhase_q <= 3'h0;
        doneSeen_q <= 1'b0;
      end else if (advance) begin
        startupPhase_q <= startupPhase_q + 3'h1;
      end
      if (state_q == css_pkg::ST_STARTUP && doneLineIn) begin
        doneSeen_q <= 1'b1;
      end
    end
  end

  // The pipelined done output moves only on startup edges, one edge late.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      doneOut_q <= 1'b0;
    end else if (clkEn) begin
      if (state_q != css_pkg::ST_STARTUP && state_q != css_pkg::ST_DONE) begin
        doneOut_q <= 1'b0;
      end else if (!options.donePipelineOption || startupStep) begin
        doneOut_q <= doneReached;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ioRelease_q <= 1'b0;
      writeEnable_q <= 1'b0;
      bramEnable_q <= 1'b0;
    end else if (clkEn) begin
      if (state_q == css_pkg::ST_DONE && configured_q) begin
        ioRelease_q <= ioRelease_q;
        writeEnable_q <= writeEnable_q;
        bramEnable_q <= bramEnable_q;
      end else if (state_q == css_pkg::ST_STARTUP) begin
        ioRelease_q <= phaseMet(options.ioReleasePhaseSelect, startupPhase_q, doneOut_q);
        writeEnable_q <= phaseMet(options.writeEnablePhaseSelect, startupPhase_q, doneOut_q);
        bramEnable_q <= phaseMet(options.writeEnablePhaseSelect, startupPhase_q, doneOut_q);
      end else if (!configured_q) begin
        ioRelease_q <= 1'b0;
        writeEnable_q <= 1'b0;
        bramEnable_q <= 1'b0;
      end
    end
  end

  // Security, port routing and global controls.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      keyFromFuse_q <= 1'b0;
      hmacCheckEn_q <= 1'b0;
      scanAccessEn_q <= 1'b1;
      globalHighHold_q <= 1'b0;
      globalSetReset_q <= 1'b0;
      portTopEn_q <= 1'b0;
      portBottomEn_q <= 1'b0;
      readbackEn_q <= 1'b1;
      readbackGrant_q <= 1'b0;
      reconfigEn_q <= 1'b1;
      converterSafe_q <= 1'b0;
    end else if (clkEn) begin
      keyFromFuse_q <= options.encryptEn && options.keySourceSelect;
      hmacCheckEn_q <= options.encryptEn && options.authEn;
      scanAccessEn_q <= !(options.jtagLockout && configured_q);
      globalHighHold_q <= state_q == css_pkg::ST_LOAD && !options.activeReconfigOption;
      globalSetReset_q <= state_q == css_pkg::ST_LOAD && !options.activeReconfigOption;
      // Automatic choice falls to the top port; both are never enabled at once.
      portTopEn_q <= options.configPortSelect != `CSS_PORT_BOTTOM;
      portBottomEn_q <= options.configPortSelect == `CSS_PORT_BOTTOM;
      readbackEn_q <= options.securityLevel == `CSS_SEC_NONE;
      readbackGrant_q <= readbackReq && options.securityLevel == `CSS_SEC_NONE;
      reconfigEn_q <= options.securityLevel != `CSS_SEC_LEVEL2;
      converterSafe_q <= partialReconfigActive && options.converterReconfigMode;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  crcMismatch_fail_a: assert property (clkEn && state_q == css_pkg::ST_LOAD && crcFail
    |=> state_q == css_pkg::ST_ERROR && configError_q) else $error("crc mismatch not failed");
  crcOff_ignore_a: assert property (clkEn && state_q == css_pkg::ST_LOAD && !options.crcEn
    && wordIn && streamWord.kind == css_pkg::KIND_CRC |=> state_q != css_pkg::ST_ERROR)
    else $error("disabled crc word was checked");
  frameFail_flag_a: assert property (clkEn && state_q == css_pkg::ST_LOAD && frameFail
    |=> partialReconfigError_q && !frameCommit_q) else $error("frame failure not flagged");
  initPin_low_a: assert property (clkEn && state_q == css_pkg::ST_ERROR &&
    options.errorSignalEn && $stable(options) |=> !initErrorN_q) else $error("init pin high");
  lockout_scan_a: assert property (configured_q && options.jtagLockout
    && clkEn |=> !scanAccessEn_q) else $error("scan access after lockout");
  active_reconfig_option_globals_a: assert property (options.activeReconfigOption &&
    clkEn |=> !globalHighHold_q && !globalSetReset_q) else $error("globals asserted");
  stall_hold_a: assert property (stall && clkEn && state_q == css_pkg::ST_STARTUP
    |=> $stable(startupPhase_q)) else $error("phase moved while stalled");
  step_single_a: assert property (state_q == css_pkg::ST_STARTUP && clkEn
    && !startupStep |=> $stable(startupPhase_q))
    else $error("phase moved without a startup edge");
  bram_gated_a: assert property (bramEnable_q |-> writeEnable_q)
    else $error("block ram enabled before write enable");
  port_exclusive_a: assert property (!(portTopEn_q && portBottomEn_q))
    else $error("both config ports enabled");
  level2_noread_a: assert property (clkEn && options.securityLevel == `CSS_SEC_LEVEL2
    |=> !readbackEn_q && !reconfigEn_q && !readbackGrant_q) else $error("level 2 leak");

  startupDone_c: cover property (state_q == css_pkg::ST_STARTUP ##1 state_q == css_pkg::ST_DONE);
  lockStall_c: cover property (stall && startupStep ##1 !stall);
  frameError_c: cover property (frameFail && state_q == css_pkg::ST_LOAD);
  debugAddr_c: cover property (options.debugStreamOption && frameCommit_q);

endmodule

// [css_consts.svh]
// Constant values for the configuration startup sequencer.
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH
`define CSS_PHASE_TIED_DONE  3'h0
`define CSS_PHASE_KEEP       3'h7
`define CSS_WAIT_NONE        3'h7
`define CSS_PHASE_FINAL      3'h7
`define CSS_DONE_PHASE_RST   3'h4
`define CSS_IO_PHASE_RST     3'h5
`define CSS_WE_PHASE_RST     3'h6
`define CSS_CLK_CONFIG       2'h0
`define CSS_CLK_USER         2'h1
`define CSS_CLK_TEST         2'h2
`define CSS_PORT_AUTO        2'h0
`define CSS_PORT_TOP         2'h1
`define CSS_PORT_BOTTOM      2'h2
`define CSS_SEC_NONE         2'h0
`define CSS_SEC_LEVEL1       2'h1
`define CSS_SEC_LEVEL2       2'h2
`define CSS_CRC_POLY         32'h04c11db7
`define CSS_CRC_SEED         32'hffffffff
`endif

// [css_pkg.sv]
// Types shared by the configuration startup sequencer.
package css_pkg;
  typedef enum logic [2:0] {
    KIND_SYNC, KIND_ADDR, KIND_DATA, KIND_FRAME_CRC, KIND_CRC, KIND_END
  } word_kind_type;
  typedef struct packed {
    logic          valid;
    word_kind_type kind;
    logic [31:0]   data;
  } stream_word_type;
  typedef struct packed {
    logic       encryptEn;
    logic       keySourceSelect;
    logic       authEn;
    logic       crcEn;
    logic       debugStreamOption;
    logic       perFrameCheckOption;
    logic       jtagLockout;
    logic       activeReconfigOption;
    logic [1:0] configPortSelect;
    logic [1:0] securityLevel;
    logic       converterReconfigMode;
    logic       donePipelineOption;
    logic [2:0] donePhaseSelect;
    logic [2:0] ioReleasePhaseSelect;
    logic [2:0] writeEnablePhaseSelect;
    logic [2:0] lockWaitPhaseSelect;
    logic [2:0] matchWaitPhaseSelect;
    logic [1:0] startupClockSelect;
    logic       errorSignalEn;
  } options_type;
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_STARTUP, ST_DONE, ST_ERROR
  } load_state_type;
endpackage

// [config_master_model.sv]
// Behavioural configuration master that pulses the configuration clock.
`timescale 1ns/1ps
module config_master_model #(
  parameter int PERIOD = 4,
  parameter int EXTRA  = 8
) (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic doneLine,
  output logic      tick
);
  int cnt   = 0;
  int extra = 0;
  initial tick = 1'b0;
  // Startup length varies with stalls, so ticks go on until done reads high, plus a few spare.
  always @(negedge clk) begin
    cnt = (cnt + 1) % PERIOD;
    if (!run) extra = 0;
    else if (doneLine && cnt == 0 && extra < EXTRA) extra++;
    tick <= run && cnt == 0 && extra < EXTRA;
  end
endmodule

// [config_startup_sequencer_tb.sv]
// Self-checking testbench for the configuration startup sequencer.
`timescale 1ns/1ps
`include "css_consts.svh"
module config_startup_sequencer_tb;
  localparam logic [31:0] ADDR_W = 32'h00012340;
  localparam logic [31:0] DATA_W = 32'h5a5a0ff0;
  logic                     clk = 1'b0;
  logic                     sys_rst = 1'b1;
  logic                     clkEn = 1'b1;
  css_pkg::options_type     opt = '0;
  css_pkg::stream_word_type sw = '0;
  logic                     hmacKeyValid = 1'b1;
  logic                     userTick = 1'b0;
  logic                     testTick = 1'b0;
  logic                     locked = 1'b1;
  logic                     rbReq = 1'b0;
  logic                     masterRun = 1'b0;
  logic                     tick;
  logic                     ramKey = 1'b1;
  logic                     hmacOk = 1'b1;
  logic                     matched = 1'b1;
  logic                     prActive = 1'b0;
  logic                     doneHold = 1'b0;
  logic                     doneLine;
  logic doneOut, initErrN, prErr, cfgErr, commit, fromFuse, scanEn, topEn, botEn;
  logic rbEn, rbGrant, reconfEn, ioRel, wrEn, bramEn, hmacChk, gHold, global_set_reset, convSafe;
  logic [31:0]              legacy;
  logic [2:0]               phase;
  int                       commits = 0;
  int                       n_mismatch = 0;
  int                       total_checks = 0;
  // The external done line can be held low by another device on the board.
  assign doneLine = doneOut & ~doneHold;
  config_startup_sequencer DUT (
    .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .options(opt), .streamWord(sw),
    .ramKeyValid(ramKey), .fuseKeyValid(1'b1), .hmacKeyValid(hmacKeyValid), .hmacMatch(hmacOk),
    .configClkTick(tick), .userStartupClockTick(userTick), .testPortClockTick(testTick),
    .allClocksLocked(locked), .impedanceMatched(matched), .doneLineIn(doneLine),
    .partialReconfigActive(prActive), .readbackReq(rbReq), .doneOut_q(doneOut),
    .initErrorN_q(initErrN), .partialReconfigError_q(prErr), .configError_q(cfgErr),
    .legacyOutputRegister_q(legacy), .frameCommit_q(commit), .keyFromFuse_q(fromFuse),
    .hmacCheckEn_q(hmacChk), .scanAccessEn_q(scanEn), .globalHighHold_q(gHold),
    .globalSetReset_q(global_set_reset), .portTopEn_q(topEn), .portBottomEn_q(botEn), .readbackEn_q(rbEn),
    .readbackGrant_q(rbGrant), .reconfigEn_q(reconfEn), .converterSafe_q(convSafe),
    .ioRelease_q(ioRel), .writeEnable_q(wrEn), .bramEnable_q(bramEn), .startupPhase_q(phase)
  );
  config_master_model #(.PERIOD(4), .EXTRA(8)) master (
    .clk(clk), .run(masterRun), .doneLine(doneLine), .tick(tick)
  );
  always #12.5 clk = ~clk;
  always @(posedge clk) if (commit === 1'b1) commits++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] d);
    logic fb;
    for (int i = 31; i >= 0; i--) begin
      fb = c[31] ^ d[i];
      c = {c[30:0], 1'b0} ^ (fb ? `CSS_CRC_POLY : 32'h0);
    end
    return c;
  endfunction
  function automatic css_pkg::options_type base();
    css_pkg::options_type o;
    o = '0;
    o.crcEn = 1'b1;
    o.perFrameCheckOption = 1'b1;
    o.debugStreamOption = 1'b1;
    o.jtagLockout = 1'b1;
    o.errorSignalEn = 1'b1;
    o.donePhaseSelect = `CSS_DONE_PHASE_RST;
    o.ioReleasePhaseSelect = `CSS_IO_PHASE_RST;
    o.writeEnablePhaseSelect = `CSS_WE_PHASE_RST;
    o.lockWaitPhaseSelect = `CSS_WAIT_NONE;
    o.matchWaitPhaseSelect = `CSS_WAIT_NONE;
    return o;
  endfunction
  task automatic send(input css_pkg::word_kind_type k, input logic [31:0] d);
    @(negedge clk);
    sw = '{1'b1, k, d};
    @(negedge clk);
    sw.valid = 1'b0;
  endtask
  task automatic restart(input css_pkg::options_type o);
    @(negedge clk);
    opt = o;
    masterRun = 1'b0;
    commits = 0;
    sys_rst = 1'b1;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
  endtask
  // Bit 0 spoils the stream check value, bit 1 the frame check value.
  task automatic load(input logic [1:0] bad);
    send(css_pkg::KIND_SYNC, 32'h0);
    send(css_pkg::KIND_ADDR, ADDR_W);
    send(css_pkg::KIND_DATA, DATA_W);
    send(css_pkg::KIND_FRAME_CRC, crc(`CSS_CRC_SEED, DATA_W) ^ {31'h0, bad[1]});
    send(css_pkg::KIND_CRC, crc(crc(`CSS_CRC_SEED, ADDR_W), DATA_W) ^ {31'h0, bad[0]});
    send(css_pkg::KIND_END, 32'h0);
    repeat (3) @(negedge clk);
  endtask
  task automatic wait_phase(input int p);
    int w;
    w = 0;
    while (phase === 3'(p - 1) && w < 50) begin
      @(negedge clk);
      w++;
    end
    chk(phase, p);
  endtask
  task automatic t_startup(input logic pipe);
    css_pkg::options_type o;
    logic dn;
    o = base();
    o.donePipelineOption = pipe;
    if (pipe) begin
      o.ioReleasePhaseSelect = `CSS_PHASE_TIED_DONE;
      o.writeEnablePhaseSelect = `CSS_PHASE_KEEP;
    end
    doneHold = pipe;
    restart(o);
    load(2'h0);
    chk(cfgErr, 0);
    chk(commits, 1);
    chk(legacy, ADDR_W);
    masterRun = 1'b1;
    for (int p = 1; p < 8; p++) begin
      if (pipe && p == 7) begin
        repeat (12) @(negedge clk);
        chk(phase, 6);
        doneHold = 1'b0;
      end
      wait_phase(p);
      repeat (2) @(negedge clk);
      // A pipelined done moves one startup edge late; a done-tied release follows it.
      dn = p >= (pipe ? 5 : 4);
      chk(doneOut, dn);
      chk(ioRel, pipe ? dn : p >= 5);
      chk(wrEn, !pipe && p >= 6);
      chk(bramEn, !pipe && p >= 6);
    end
    chk(scanEn, 0);
    $display("test startup done");
  endtask
  task automatic t_errors();
    css_pkg::options_type o;
    restart(base());
    load(2'h1);
    chk(cfgErr, 1);
    chk(initErrN, 0);
    restart(base());
    load(2'h2);
    chk(prErr, 1);
    chk(initErrN, 0);
    o = base();
    o.errorSignalEn = 1'b0;
    restart(o);
    load(2'h1);
    chk(initErrN, 1);
    o.crcEn = 1'b0;
    restart(o);
    load(2'h1);
    chk(cfgErr, 0);
    o = base();
    o.encryptEn = 1'b1;
    o.authEn = 1'b1;
    hmacKeyValid = 1'b0;
    restart(o);
    load(2'h0);
    chk(cfgErr, 1);
    hmacKeyValid = 1'b1;
    hmacOk = 1'b0;
    restart(o);
    load(2'h0);
    chk(cfgErr, 1);
    hmacOk = 1'b1;
    o.authEn = 1'b0;
    o.keySourceSelect = 1'b1;
    ramKey = 1'b0;
    restart(o);
    load(2'h0);
    chk(cfgErr, 0);
    o.keySourceSelect = 1'b0;
    restart(o);
    load(2'h0);
    chk(cfgErr, 1);
    ramKey = 1'b1;
    $display("test errors done");
  endtask
  task automatic t_controls();
    css_pkg::options_type o;
    for (int i = 0; i < 4; i++) begin
      o = base();
      o.encryptEn = i[0];
      o.keySourceSelect = i[1];
      o.authEn = i[1];
      o.activeReconfigOption = i[1];
      o.converterReconfigMode = i[1];
      o.configPortSelect = 2'(i % 3);
      o.securityLevel = 2'(i % 3);
      prActive = i[0];
      restart(o);
      rbReq = 1'b1;
      send(css_pkg::KIND_SYNC, 32'h0);
      @(negedge clk);
      chk(fromFuse, i == 3);
      chk(hmacChk, i == 3);
      chk(gHold, !i[1]);
      chk(global_set_reset, !i[1]);
      chk(convSafe, i == 3);
      chk(topEn, i % 3 != 2);
      chk(botEn, i % 3 == 2);
      chk(rbEn, i % 3 == 0);
      chk(reconfEn, i % 3 != 2);
      chk(rbGrant, i % 3 == 0);
      rbReq = 1'b0;
    end
    prActive = 1'b0;
    $display("test controls done");
  endtask
  task automatic t_stalls();
    css_pkg::options_type o;
    o = base();
    o.lockWaitPhaseSelect = 3'h2;
    o.matchWaitPhaseSelect = 3'h3;
    locked = 1'b0;
    matched = 1'b0;
    restart(o);
    load(2'h0);
    masterRun = 1'b1;
    repeat (60) @(negedge clk);
    chk(phase, 2);
    locked = 1'b1;
    repeat (60) @(negedge clk);
    chk(phase, 3);
    matched = 1'b1;
    repeat (40) @(negedge clk);
    chk(phase, 7);
    o = base();
    o.startupClockSelect = `CSS_CLK_USER;
    restart(o);
    load(2'h0);
    for (int i = 0; i < 4; i++) begin
      clkEn = (i != 1);
      testTick = (i == 2);
      userTick = (i != 2);
      @(negedge clk);
      userTick = 1'b0;
      testTick = 1'b0;
      clkEn = 1'b1;
      @(negedge clk);
    end
    chk(phase, 2);
    opt.startupClockSelect = `CSS_CLK_TEST;
    userTick = 1'b1;
    @(negedge clk);
    userTick = 1'b0;
    testTick = 1'b1;
    @(negedge clk);
    testTick = 1'b0;
    @(negedge clk);
    chk(phase, 3);
    $display("test stalls done");
  endtask
  initial begin
    t_startup(1'b0);
    t_startup(1'b1);
    t_errors();
    t_controls();
    t_stalls();
    give_verdict();
  end
  initial begin
    #(25 * 8000);
    n_mismatch++;
    give_verdict();
  end
endmodule
